/* File: verilog/acrs_calibration_sequencer.v */
`timescale 1ns/100ps
`include "acrs_map.vh"
// Function
// - Detector frees the line once supplies settle; pull-up starts it.
// - Every rising edge of the trigger line starts a calibration.
// - Over-range flag high while trigger low, until calibration finishes.
// - Over-range input during completion keeps the flag high.
// - Output clock held low while trigger is low.
// - Output clock resumes at the next divider enable after release.
// - Calibration nominally 200 ms, never over 550 ms.
// - Divider sits in series with the input clock; enables phase slip.
// - Divider pin: low divides by 2, floating by 1, high by 4.
// - Serially programmed divide ratio overrides the divider pin.
// - Allow up to 52 us relock after any input clock change; the code restarts the relock wait only on a divide-ratio change.
module acrs_calibration_sequencer #(
  parameter CAL_CYCLES = `ACRS_CAL_NOM_CYC,
  parameter LOCK_CYCLES = `ACRS_LOCK_CYC
) (
  // Clock and reset.
  input wire core_clk,
  input wire reset,
  // Power-on detector and trigger line (open drain).
  input wire supply_good,
  input wire calibration_trigger_n_in,
  output wire calibration_trigger_n_out,
  output wire calibration_trigger_n_oe,
  // Divider controls.
  input wire [1:0] divider_select_pin,
  input wire cfg_div_valid,
  input wire [1:0] cfg_div_code,
  input wire phase_slip,
  // Converter status and outputs.
  input wire over_range_in,
  output reg over_range_reg,
  output reg output_clock_reg,
  output wire sample_enable,
  output reg cal_busy_reg,
  output reg dll_locked_reg
);
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [24:0] count_reg;
  reg [24:0] count_next;
  reg trig_prev_reg;
  reg por_hold_reg;
  reg seen_low_reg;
  reg [11:0] lock_reg;
  wire [1:0] div_code;
  wire div_change;
  wire div_tick;
  wire trig_low;
  wire trig_rise;

  // The detector holds the line low until supplies are good, then lets go.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      por_hold_reg <= 1'b1;
    end else if (supply_good) begin
      por_hold_reg <= 1'b0;
    end
  end

  // Open-drain: drive only a low; the pull-up supplies the high level.
  assign calibration_trigger_n_out = 1'b0;
  assign calibration_trigger_n_oe = por_hold_reg;

  // The line level is the wired result seen on the input pin.
  assign trig_low = ~calibration_trigger_n_in;
  // A rise needs a low seen first, so a line high from reset does not fire.
  assign trig_rise = seen_low_reg & trig_prev_reg == 1'b0 & ~trig_low;

  // Edge history of the trigger line.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trig_prev_reg <= 1'b1;
      seen_low_reg <= 1'b0;
    end else begin
      trig_prev_reg <= ~trig_low;
      if (trig_low) begin
        seen_low_reg <= 1'b1;
      end
    end
  end

  // Ratio selection from pin or serial setting.
  acrs_divider_select u_select (
    .core_clk(core_clk),
    .reset(reset),
    .divider_select_pin(divider_select_pin),
    .cfg_div_valid(cfg_div_valid),
    .cfg_div_code(cfg_div_code),
    .div_code_reg(div_code),
    .div_change_reg(div_change)
  );

  // Divider in series with the conversion clock.
  acrs_clock_divider u_divider (
    .core_clk(core_clk),
    .reset(reset),
    .div_code(div_code),
    .sync_clear(phase_slip),
    .div_tick(div_tick)
  );

  assign sample_enable = div_tick;

  // Relock counter restarts on a ratio change; locked when it runs out.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lock_reg <= 12'h000;
      dll_locked_reg <= 1'b0;
    end else if (div_change) begin
      lock_reg <= 12'h000;
      dll_locked_reg <= 1'b0;
    end else if (lock_reg < LOCK_CYCLES[11:0] - 12'h001) begin
      lock_reg <= lock_reg + 12'h001;
    end else begin
      dll_locked_reg <= 1'b1;
    end
  end

  // Sequencer: held while low, start on the rising edge, then count.
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    if (trig_low) begin
      state_next = `ACRS_ST_HELD;
      count_next = 25'h0000000;
    end else begin
      case (state_reg)
        `ACRS_ST_IDLE: begin
          if (trig_rise) begin
            state_next = `ACRS_ST_CAL;
          end
        end
        `ACRS_ST_HELD: begin
          state_next = `ACRS_ST_CAL;
        end
        `ACRS_ST_CAL: begin
          // Counting every core_clk keeps the length fixed whatever the ratio.
          if (count_reg >= CAL_CYCLES[24:0] - 25'h0000001) begin
            state_next = `ACRS_ST_IDLE;
          end else begin
            count_next = count_reg + 25'h0000001;
          end
        end
        default: state_next = `ACRS_ST_IDLE;
      endcase
    end
  end

  // State and counter registers.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= `ACRS_ST_IDLE;
      count_reg <= 25'h0000000;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Busy while low or while calibrating; the over-range flag below uses the same condition.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cal_busy_reg <= 1'b1;
    end else begin
      cal_busy_reg <= trig_low | (state_next != `ACRS_ST_IDLE);
    end
  end

  // Over-range forced high when busy; normal report otherwise.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      over_range_reg <= 1'b1;
    end else if (trig_low || state_next != `ACRS_ST_IDLE) begin
      over_range_reg <= 1'b1;
    end else begin
      over_range_reg <= over_range_in;
    end
  end

  // Output clock low while the line is low; toggles at each enable after.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      output_clock_reg <= 1'b0;
    end else if (trig_low) begin
      output_clock_reg <= 1'b0;
    end else if (div_tick) begin
      output_clock_reg <= ~output_clock_reg;
    end
  end
endmodule

/* File: verilog/acrs_map.vh */
`ifndef ACRS_MAP_VH
`define ACRS_MAP_VH
// Clock rate of core_clk in kHz.
`define ACRS_CLK_KHZ 50000
// Calibration times in milliseconds.
`define ACRS_CAL_NOM_MS 200
`define ACRS_CAL_MAX_MS 550
// Cycle count for the nominal calibration time, an exact product with no rounding.
`define ACRS_CAL_NOM_CYC (`ACRS_CAL_NOM_MS * `ACRS_CLK_KHZ)
// Delay-locked loop relock time in microseconds.
`define ACRS_LOCK_US 52
// Relock cycle count at the top rate, rounded up.
`define ACRS_LOCK_CYC ((`ACRS_LOCK_US * `ACRS_CLK_KHZ + 999) / 1000)
// Divider select pin encodings.
`define ACRS_DIVSEL_LOW 2'h0
`define ACRS_DIVSEL_FLOAT 2'h1
`define ACRS_DIVSEL_HIGH 2'h2
// Divide ratio codes.
`define ACRS_DIV1 2'h0
`define ACRS_DIV2 2'h1
`define ACRS_DIV4 2'h2
// Calibration sequencer states.
`define ACRS_ST_IDLE 2'h0
`define ACRS_ST_HELD 2'h1
`define ACRS_ST_LOCK 2'h2
`define ACRS_ST_CAL 2'h3
`endif

/* File: verilog/acrs_clock_divider.v */
`timescale 1ns/100ps
`include "acrs_map.vh"
// Divides core_clk into a one-cycle enable at rate 1, 1/2 or 1/4.
module acrs_clock_divider (
  // Clock and reset.
  input wire core_clk,
  input wire reset,
  // Control.
  input wire [1:0] div_code,
  input wire sync_clear,
  // Divided enable.
  output wire div_tick
);
  reg [1:0] count_reg;
  reg [1:0] count_next;
  reg tick;

  // Phase slip: sync_clear restarts the count so converters line up.
  always @* begin
    tick = 1'b0;
    count_next = count_reg + 2'h1;
    case (div_code)
      `ACRS_DIV2: tick = (count_reg[0] == 1'b1);
      `ACRS_DIV4: tick = (count_reg == 2'h3);
      default: tick = 1'b1;
    endcase
    if (sync_clear) begin
      count_next = 2'h0;
    end
  end

  // Counter register.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_reg <= 2'h0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign div_tick = tick & ~sync_clear;
endmodule

/* File: verilog/acrs_divider_select.v */
`timescale 1ns/100ps
`include "acrs_map.vh"
// Picks the divide ratio from the pin, unless software has programmed one.
module acrs_divider_select (
  // Clock and reset.
  input wire core_clk,
  input wire reset,
  // Pin and serial-port setting.
  input wire [1:0] divider_select_pin,
  input wire cfg_div_valid,
  input wire [1:0] cfg_div_code,
  // Result.
  output reg [1:0] div_code_reg,
  output reg div_change_reg
);
  reg prog_reg;
  reg [1:0] prog_code_reg;
  reg [1:0] div_code_next;

  // Translate the three-level pin to a ratio code.
  function [1:0] acrs_pin_ratio;
    input [1:0] pin;
    begin
      case (pin)
        `ACRS_DIVSEL_LOW: acrs_pin_ratio = `ACRS_DIV2;
        `ACRS_DIVSEL_HIGH: acrs_pin_ratio = `ACRS_DIV4;
        default: acrs_pin_ratio = `ACRS_DIV1;
      endcase
    end
  endfunction

  // A programmed ratio sticks until reset and overrides the pin.
  always @* begin
    if (prog_reg) begin
      div_code_next = prog_code_reg;
    end else begin
      div_code_next = acrs_pin_ratio(divider_select_pin);
    end
  end

  // Registered ratio; a change is flagged so the lock wait restarts.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prog_reg <= 1'b0;
      prog_code_reg <= `ACRS_DIV1;
      div_code_reg <= `ACRS_DIV1;
      div_change_reg <= 1'b0;
    end else begin
      if (cfg_div_valid && cfg_div_code != 2'h3) begin
        prog_reg <= 1'b1;
        prog_code_reg <= cfg_div_code;
      end
      div_code_reg <= div_code_next;
      div_change_reg <= (div_code_next != div_code_reg);
    end
  end
endmodule

/* File: tb/acrs_host_model.sv */
`timescale 1ns/100ps
// Host side of the trigger line: an open-drain pull plus a serial data out level.
// Its serial data out is tied high, so it can never talk during calibration.
module acrs_host_model (
  // Clock.
  input wire core_clk,
  // Request from the bench.
  input wire req,
  // Pull-down enable and serial data out level.
  output wire pull_low,
  output wire sdo_level
);
  reg [1:0] hold_reg = 2'h0;
  // Serial data out rests high so every calibration is valid.
  assign sdo_level = 1'b1;
  // Pull low for two cycles, above the one-cycle minimum.
  always @(posedge core_clk) begin
    if (req) begin
      hold_reg <= 2'h2;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
  end
  // Only ever pulls down; the pull-up raises the line.
  assign pull_low = hold_reg != 2'h0;
endmodule

/* File: tb/acrs_cal_asserts.sv */
`timescale 1ns/100ps
// Watches the sequencer pins; the window allows a few cycles of pipeline.
module acrs_cal_checker #(
  parameter CAL_CYCLES = 20
) (
  input wire core_clk,
  input wire reset,
  input wire supply_good,
  input wire calibration_trigger_n_in,
  input wire calibration_trigger_n_out,
  input wire calibration_trigger_n_oe,
  input wire over_range_in,
  input wire over_range_reg,
  input wire output_clock_reg,
  input wire sample_enable,
  input wire cal_busy_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  reg [31:0] hi_cnt_reg;
  // Cycles since the trigger line was last seen low.
  always @(posedge core_clk or posedge reset) begin
    if (reset || !calibration_trigger_n_in) begin
      hi_cnt_reg <= 32'h0;
    end else begin
      hi_cnt_reg <= hi_cnt_reg + 32'h1;
    end
  end
  sequence rel_s;
    $rose(calibration_trigger_n_in);
  endsequence
  sequence done_s;
    $fell(cal_busy_reg);
  endsequence
  busy_on_low_a: assert property (!calibration_trigger_n_in |=> cal_busy_reg)
    else $error("busy not set by low trigger");
  or_forced_a: assert property (!calibration_trigger_n_in |=> over_range_reg)
    else $error("over-range not forced");
  clk_held_a: assert property (!calibration_trigger_n_in |=> !output_clock_reg)
    else $error("output clock not held low");
  or_follow_a: assert property (!cal_busy_reg && $past(!cal_busy_reg)
    |-> over_range_reg == $past(over_range_in)) else $error("over-range lost");
  rise_start_a: assert property (rel_s |-> cal_busy_reg)
    else $error("rise did not start calibration");
  cal_done_a: assert property (done_s |-> hi_cnt_reg >= CAL_CYCLES
    && hi_cnt_reg <= CAL_CYCLES + 3) else $error("calibration length wrong");
  cal_bound_a: assert property (cal_busy_reg |-> hi_cnt_reg <= CAL_CYCLES + 3)
    else $error("calibration overran");
  clk_resume_a: assert property (!cal_busy_reg && sample_enable
    && calibration_trigger_n_in |=> output_clock_reg != $past(output_clock_reg))
    else $error("output clock did not toggle");
  por_release_a: assert property (supply_good |=> !calibration_trigger_n_oe)
    else $error("detector kept line low");
  drive_low_a: assert property (!calibration_trigger_n_out)
    else $error("trigger driven high");
endmodule
bind acrs_calibration_sequencer acrs_cal_checker #(.CAL_CYCLES(CAL_CYCLES)) i_chk (
  .core_clk(core_clk), .reset(reset), .supply_good(supply_good),
  .calibration_trigger_n_in(calibration_trigger_n_in),
  .calibration_trigger_n_out(calibration_trigger_n_out),
  .calibration_trigger_n_oe(calibration_trigger_n_oe),
  .over_range_in(over_range_in), .over_range_reg(over_range_reg),
  .output_clock_reg(output_clock_reg), .sample_enable(sample_enable),
  .cal_busy_reg(cal_busy_reg));

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
  localparam CAL = 20;
  reg core_clk, reset, supply_good, req, cfg_div_valid, phase_slip, ovr_in;
  reg [1:0] pin, cfg_code;
  wire trig_n, t_out, t_oe, ovr, oclk, se, busy, locked, pull_low, sdo;
  int fails = 0, num_checks = 0, cycles = 0, n;
  // Open-drain wire with pull-up: any low enable wins.
  assign trig_n = (pull_low || (t_oe && !t_out)) ? 1'b0 : 1'b1;
  acrs_calibration_sequencer #(.CAL_CYCLES(CAL), .LOCK_CYCLES(8))
  i_acrs_calibration_sequencer (.core_clk(core_clk), .reset(reset),
    .supply_good(supply_good), .calibration_trigger_n_in(trig_n),
    .calibration_trigger_n_out(t_out), .calibration_trigger_n_oe(t_oe),
    .divider_select_pin(pin), .cfg_div_valid(cfg_div_valid),
    .cfg_div_code(cfg_code), .phase_slip(phase_slip), .over_range_in(ovr_in),
    .over_range_reg(ovr), .output_clock_reg(oclk), .sample_enable(se),
    .cal_busy_reg(busy), .dll_locked_reg(locked));
  acrs_host_model i_acrs_host_model (.core_clk(core_clk), .req(req),
    .pull_low(pull_low), .sdo_level(sdo));
  // Fixed period throughout, the top rate of this bench.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // Waits for the end of calibration and checks its length.
  task wait_idle;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    chk("cal length", 1, n >= CAL && n <= CAL + 6);
  endtask
  task power_on;
    tick(3);
    chk("busy before supply", 1, busy);
    chk("detector hold", 1, t_oe);
    supply_good = 1'b1;
    wait_idle;
  endtask
  task user_recal(input logic ovr_level);
    ovr_in = ovr_level;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    tick(1);
    chk("forced over-range", 1, ovr);
    chk("held clock", 0, oclk);
    wait_idle;
    tick(2);
    chk("over-range after", ovr_level, ovr);
    ovr_in = 1'b0;
    tick(2);
    chk("over-range normal", 0, ovr);
  endtask
  task count_se(input string what, input int exp);
    int c;
    c = 0;
    tick(4);
    // Sample the enable just after each edge, where it has settled.
    repeat (16) begin
      c += se;
      tick(1);
    end
    chk(what, exp, c);
  endtask
  task divider;
    int exp_tab[3] = '{8, 16, 4};
    for (int p = 0; p < 3; p++) begin
      pin = p[1:0];
      count_se("pin ratio", exp_tab[p]);
    end
    pin = 2'h1;
    cfg_code = 2'h1;
    cfg_div_valid = 1'b1;
    tick(1);
    cfg_div_valid = 1'b0;
    phase_slip = 1'b1;
    tick(1);
    phase_slip = 1'b0;
    count_se("serial ratio", 8);
    chk("relocked", 1, locked);
    cfg_code = 2'h3;
    cfg_div_valid = 1'b1;
    tick(1);
    cfg_div_valid = 1'b0;
    count_se("code 3 ignored", 8);
  endtask
  initial begin
    reset = 1'b1;
    supply_good = 1'b0;
    req = 1'b0;
    cfg_div_valid = 1'b0;
    cfg_code = 2'h0;
    phase_slip = 1'b0;
    ovr_in = 1'b0;
    pin = 2'h1;
    tick(4);
    reset = 1'b0;
    power_on;
    user_recal(1'b0);
    user_recal(1'b1);
    divider;
    tally_and_finish;
  end
endmodule
